// File: pkg/pia_pkg.sv
// Constants for the interrupt summary and masking block.
// Assumes register access by command code, one data byte per register.
package pia_pkg;

  // Command codes
  localparam logic [7:0] CMD_SUMMARY   = 8'h00;
  localparam logic [7:0] CMD_ENABLE    = 8'h01;
  localparam logic [7:0] CMD_POWER_COR = 8'h03;
  localparam logic [7:0] CMD_DETECT_COR = 8'h05;
  localparam logic [7:0] CMD_FAULT_COR = 8'h07;
  localparam logic [7:0] CMD_START_COR = 8'h09;
  localparam logic [7:0] CMD_SUPPLY_COR = 8'h0b;

  // Summary bit positions
  localparam int BIT_SUPPLY   = 7;
  localparam int BIT_START    = 6;
  localparam int BIT_CURRENT  = 5;
  localparam int BIT_CLASS    = 4;
  localparam int BIT_DETECT   = 3;
  localparam int BIT_DISCON   = 2;
  localparam int BIT_PGOOD    = 1;
  localparam int BIT_PENABLE  = 0;

  // Summary bits fed by each clear-on-read event register
  localparam logic [7:0] CLR_POWER  = 8'h03;
  localparam logic [7:0] CLR_DETECT = 8'h18;
  localparam logic [7:0] CLR_FAULT  = 8'h24;
  localparam logic [7:0] CLR_START  = 8'h60;
  localparam logic [7:0] CLR_SUPPLY = 8'h80;

  // Reset values; enable bits under AUTO_MASK follow the auto-mode strap
  localparam logic [7:0] SUMMARY_RESET = 8'h80;
  localparam logic [7:0] ENABLE_RESET  = 8'h80;
  localparam logic [7:0] ENABLE_AUTO_MASK = 8'h64;

endpackage : pia_pkg

// File: hw/pia_flag_reduce.sv
// Reduces the per-port and supply event flags to eight raw summary bits.
// Assumes the flags come from event registers clocked by mclk.
module pia_flag_reduce (
  input  wire logic       thermalShutdownFlag,
  input  wire logic       logicSupplyUvFlag,
  input  wire logic       powerSupplyUvFlag,
  input  wire logic [3:0] portStartFaultFlag,
  input  wire logic [3:0] portOvercurrentCutFlag,
  input  wire logic [3:0] portCurrentLimitFlag,
  input  wire logic [3:0] portClassificationFlag,
  input  wire logic [3:0] portDetectionFlag,
  input  wire logic [3:0] portDisconnectFlag,
  input  wire logic [3:0] portPowerGoodChangeFlag,
  input  wire logic [3:0] portPowerEnableChangeFlag,
  output logic      [7:0] rawSummary
);

  // One OR per summary position, active high
  always_comb begin
    rawSummary = 8'h00;
    rawSummary[pia_pkg::BIT_SUPPLY]  = thermalShutdownFlag | logicSupplyUvFlag
                                       | powerSupplyUvFlag;
    rawSummary[pia_pkg::BIT_START]   = |portStartFaultFlag;
    rawSummary[pia_pkg::BIT_CURRENT] = |{portOvercurrentCutFlag, portCurrentLimitFlag};
    rawSummary[pia_pkg::BIT_CLASS]   = |portClassificationFlag;
    rawSummary[pia_pkg::BIT_DETECT]  = |portDetectionFlag;
    rawSummary[pia_pkg::BIT_DISCON]  = |portDisconnectFlag;
    rawSummary[pia_pkg::BIT_PGOOD]   = |portPowerGoodChangeFlag;
    rawSummary[pia_pkg::BIT_PENABLE] = |portPowerEnableChangeFlag;
  end

endmodule : pia_flag_reduce

// File: hw/pia_irq_summary.sv
// Interrupt summary status, source enable and interrupt pin logic.
// Assumes a command-code register port in the mclk domain and
// event flags plus global enable from neighbouring register logic.
//
// Contract
// - Supply bit is OR of three supply flags
// - Start bit is OR of port start faults
// - Current bit ORs overcurrent and limit flags
// - Classification bit ORs port classification flags
// - Detection bit ORs port detection flags
// - Disconnect bit ORs port disconnect flags
// - Power-good bit ORs port power-good changes
// - Power-enable bit ORs port enable changes
// - Summary bits are active high
// - Clear per event read, or all via global clear
// - Interrupt needs bit, enable and global enable
// - Summary at code 00h, read only
// - Enable at code 01h, read/write, bitwise mask
// - Enable one passes, zero blocks the event
// - Masking never alters summary values
// - Auto-marked enables take auto mode at reset
// - Clear-on-read address clears, plain address not
module pia_irq_summary (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       thermalShutdownFlag,
  input  wire logic       logicSupplyUvFlag,
  input  wire logic       powerSupplyUvFlag,
  input  wire logic [3:0] portStartFaultFlag,
  input  wire logic [3:0] portOvercurrentCutFlag,
  input  wire logic [3:0] portCurrentLimitFlag,
  input  wire logic [3:0] portClassificationFlag,
  input  wire logic [3:0] portDetectionFlag,
  input  wire logic [3:0] portDisconnectFlag,
  input  wire logic [3:0] portPowerGoodChangeFlag,
  input  wire logic [3:0] portPowerEnableChangeFlag,
  input  wire logic       globalIrqEnable,
  input  wire logic       autoMode,
  input  wire logic       clearAllSummary,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrEn,
  input  wire logic [7:0] regWrData,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  output logic            irqN
);

  typedef struct packed {
    logic [7:0] summary;
    logic [7:0] enable;
    logic [7:0] rdData;
    logic       irqN;
  } pia_state_t;

  pia_state_t state_q;
  pia_state_t state_d;
  logic [7:0] rawSummary;

  // Summary bits a read at a command code clears; zero for plain addresses
  function automatic logic [7:0] clearMask(input logic [7:0] addr);
    unique case (addr)
      pia_pkg::CMD_POWER_COR:  clearMask = pia_pkg::CLR_POWER;
      pia_pkg::CMD_DETECT_COR: clearMask = pia_pkg::CLR_DETECT;
      pia_pkg::CMD_FAULT_COR:  clearMask = pia_pkg::CLR_FAULT;
      pia_pkg::CMD_START_COR:  clearMask = pia_pkg::CLR_START;
      pia_pkg::CMD_SUPPLY_COR: clearMask = pia_pkg::CLR_SUPPLY;
      default:                 clearMask = 8'h00;
    endcase
  endfunction : clearMask

  // Flag reduction to raw summary bits
  pia_flag_reduce u_reduce (
    .thermalShutdownFlag       (thermalShutdownFlag),
    .logicSupplyUvFlag         (logicSupplyUvFlag),
    .powerSupplyUvFlag         (powerSupplyUvFlag),
    .portStartFaultFlag        (portStartFaultFlag),
    .portOvercurrentCutFlag    (portOvercurrentCutFlag),
    .portCurrentLimitFlag      (portCurrentLimitFlag),
    .portClassificationFlag    (portClassificationFlag),
    .portDetectionFlag         (portDetectionFlag),
    .portDisconnectFlag        (portDisconnectFlag),
    .portPowerGoodChangeFlag   (portPowerGoodChangeFlag),
    .portPowerEnableChangeFlag (portPowerEnableChangeFlag),
    .rawSummary                (rawSummary)
  );

  // Next-state logic for the whole block
  always_comb begin
    logic [7:0] clr;
    logic [7:0] live;
    clr  = 8'h00;
    live = 8'h00;
    state_d = state_q;
    // Clear-on-read strobes and global clear; a live flag still wins
    if (regRdEn) begin
      clr = clearMask(regAddr);
    end
    if (clearAllSummary) begin
      clr = 8'hff;
    end
    state_d.summary = (state_q.summary & ~clr) | rawSummary;
    // Enable register write; summary code ignores writes
    if (regWrEn && regAddr == pia_pkg::CMD_ENABLE) begin
      state_d.enable = regWrData;
    end
    // Read data, zero for codes this block does not own
    if (regRdEn) begin
      unique case (regAddr)
        pia_pkg::CMD_SUMMARY: state_d.rdData = state_q.summary;
        pia_pkg::CMD_ENABLE:  state_d.rdData = state_q.enable;
        default:              state_d.rdData = 8'h00;
      endcase
    end
    // Active-low pin from enabled, globally permitted bits
    live = state_q.summary & state_q.enable;
    state_d.irqN = !(globalIrqEnable && (|live));
    // Reset values; auto-marked enables copy the auto-mode strap
    if (srst) begin
      state_d.summary = pia_pkg::SUMMARY_RESET;
      state_d.enable  = pia_pkg::ENABLE_RESET
                        | (pia_pkg::ENABLE_AUTO_MASK & {8{autoMode}});
      state_d.rdData  = 8'h00;
      state_d.irqN    = 1'b1;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    state_q <= state_d;
  end

  assign regRdData = state_q.rdData;
  assign irqN      = state_q.irqN;

  // Checks on the summary, enable and pin behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_supply_or_set: assert property (
    (thermalShutdownFlag || logicSupplyUvFlag || powerSupplyUvFlag) |=> state_q.summary[7])
    else $error("supply summary bit not set by supply flag");

  a_current_or_set: assert property (
    (|portCurrentLimitFlag) |=> state_q.summary[5])
    else $error("current summary bit not set by limit flag");

  a_start_or_set: assert property (
    (|portStartFaultFlag) |=> state_q.summary[6])
    else $error("start summary bit not set by start flag");

  a_power_clear_read: assert property (
    (regRdEn && regAddr == 8'h03 && !clearAllSummary && rawSummary[1:0] == 2'b00)
      |=> state_q.summary[1:0] == 2'b00)
    else $error("power summary bits survived clear-on-read");

  a_plain_read_keeps: assert property (
    (regRdEn && regAddr == 8'h02 && !clearAllSummary && state_q.summary[1])
      |=> state_q.summary[1])
    else $error("plain address read cleared a summary bit");

  a_clear_all: assert property (
    (clearAllSummary && rawSummary == 8'h00) |=> state_q.summary == 8'h00)
    else $error("global clear left summary bits set");

  a_enable_write: assert property (
    (regWrEn && regAddr == 8'h01) |=> state_q.enable == $past(regWrData))
    else $error("enable register did not take written byte");

  a_summary_ro: assert property (
    (regWrEn && regAddr == 8'h00 && !regRdEn && !clearAllSummary)
      |=> state_q.summary == ($past(state_q.summary) | $past(rawSummary)))
    else $error("write to summary code changed summary");

  a_irq_assert: assert property (
    (globalIrqEnable && (|(state_q.summary & state_q.enable))) |=> !irqN)
    else $error("interrupt pin not driven low");

  a_irq_masked: assert property (
    ((state_q.summary & state_q.enable) == 8'h00 || !globalIrqEnable) |=> irqN)
    else $error("interrupt pin low while masked");

  a_masked_still_sets: assert property (
    (state_q.enable[4] == 1'b0 && (|portClassificationFlag)) |=> state_q.summary[4])
    else $error("masked summary bit failed to set");

  a_enable_reset: assert property (
    $past(srst) |-> state_q.enable == (8'h80 | (8'h64 & {8{$past(autoMode)}})))
    else $error("enable reset value wrong");

  a_read_enable: assert property (
    (regRdEn && regAddr == 8'h01) |=> regRdData == $past(state_q.enable))
    else $error("enable read data wrong");

  // Remaining set paths
  a_overcut_or_set: assert property (
    (|portOvercurrentCutFlag) |=> state_q.summary[pia_pkg::BIT_CURRENT])
    else $error("current summary bit not set by overcurrent flag");

  a_class_or_set: assert property (
    (|portClassificationFlag) |=> state_q.summary[pia_pkg::BIT_CLASS])
    else $error("classification summary bit not set");

  a_detect_or_set: assert property (
    (|portDetectionFlag) |=> state_q.summary[pia_pkg::BIT_DETECT])
    else $error("detection summary bit not set");

  a_discon_or_set: assert property (
    (|portDisconnectFlag) |=> state_q.summary[pia_pkg::BIT_DISCON])
    else $error("disconnect summary bit not set");

  a_pgood_or_set: assert property (
    (|portPowerGoodChangeFlag) |=> state_q.summary[pia_pkg::BIT_PGOOD])
    else $error("power-good summary bit not set");

  a_penable_or_set: assert property (
    (|portPowerEnableChangeFlag) |=> state_q.summary[pia_pkg::BIT_PENABLE])
    else $error("power-enable summary bit not set");

  // Clear-on-read of the other event codes
  a_detect_clear_read: assert property (
    (regRdEn && regAddr == pia_pkg::CMD_DETECT_COR && !clearAllSummary
      && (rawSummary & pia_pkg::CLR_DETECT) == 8'h00) |=> (state_q.summary & pia_pkg::CLR_DETECT) == 8'h00)
    else $error("detection summary bits survived clear-on-read");

  a_fault_clear_read: assert property (
    (regRdEn && regAddr == pia_pkg::CMD_FAULT_COR && !clearAllSummary
      && (rawSummary & pia_pkg::CLR_FAULT) == 8'h00) |=> (state_q.summary & pia_pkg::CLR_FAULT) == 8'h00)
    else $error("fault summary bits survived clear-on-read");

  a_start_clear_read: assert property (
    (regRdEn && regAddr == pia_pkg::CMD_START_COR && !clearAllSummary
      && (rawSummary & pia_pkg::CLR_START) == 8'h00) |=> (state_q.summary & pia_pkg::CLR_START) == 8'h00)
    else $error("start summary bits survived clear-on-read");

  a_supply_clear_read: assert property (
    (regRdEn && regAddr == pia_pkg::CMD_SUPPLY_COR && !clearAllSummary
      && (rawSummary & pia_pkg::CLR_SUPPLY) == 8'h00) |=> (state_q.summary & pia_pkg::CLR_SUPPLY) == 8'h00)
    else $error("supply summary bit survived clear-on-read");

  // Sticky behaviour of the summary bits
  a_sticky_hold: assert property (
    (!regRdEn && !clearAllSummary) |=> (state_q.summary & $past(state_q.summary)) == $past(state_q.summary))
    else $error("summary bit dropped without a clear");

  a_no_spurious_set: assert property (
    1'b1 |=> (state_q.summary & ~$past(state_q.summary) & ~$past(rawSummary)) == 8'h00)
    else $error("summary bit set without a flag");

  a_live_flag_wins: assert property (
    1'b1 |=> (state_q.summary & $past(rawSummary)) == $past(rawSummary))
    else $error("live flag lost against a clear");

  a_masked_set_all: assert property (
    (state_q.enable == 8'h00) |=> (state_q.summary & $past(rawSummary)) == $past(rawSummary))
    else $error("summary bits blocked by zero enable");

  a_plain_codes_keep: assert property (
    (regRdEn && !regAddr[0] && !clearAllSummary)
      |=> state_q.summary == ($past(state_q.summary) | $past(rawSummary)))
    else $error("plain code read changed summary");

  // Register port
  a_read_summary: assert property (
    (regRdEn && regAddr == pia_pkg::CMD_SUMMARY) |=> regRdData == $past(state_q.summary))
    else $error("summary read data wrong");

  a_unowned_read: assert property (
    (regRdEn && regAddr != pia_pkg::CMD_SUMMARY && regAddr != pia_pkg::CMD_ENABLE) |=> regRdData == 8'h00)
    else $error("unowned code read not zero");

  a_rddata_holds: assert property (
    !regRdEn |=> $stable(regRdData))
    else $error("read data changed without a read");

  a_enable_keeps: assert property (
    !(regWrEn && regAddr == pia_pkg::CMD_ENABLE) |=> $stable(state_q.enable))
    else $error("enable changed without a write");

  // Reset values
  a_summary_reset: assert property (
    $past(srst) |-> state_q.summary == pia_pkg::SUMMARY_RESET)
    else $error("summary reset value wrong");

  a_reset_pin_high: assert property (
    $past(srst) |-> irqN)
    else $error("interrupt pin low after reset");

  a_reset_rd_zero: assert property (
    $past(srst) |-> regRdData == 8'h00)
    else $error("read data not zero after reset");

  // Pin
  a_gie_blocks: assert property (
    !globalIrqEnable |=> irqN)
    else $error("interrupt pin low with global enable off");

  a_enable_zero_quiet: assert property (
    (state_q.enable == 8'h00) |=> irqN)
    else $error("interrupt pin low with all enables off");

  a_irq_exact: assert property (
    1'b1 |=> irqN == !($past(globalIrqEnable) && (|($past(state_q.summary) & $past(state_q.enable)))))
    else $error("interrupt pin differs from enabled summary");

  c_irq_low:    cover property (!irqN ##1 irqN);
  c_cor_clear:  cover property (state_q.summary[3] ##1 (regRdEn && regAddr == 8'h05) ##1 !state_q.summary[3]);
  c_clear_all:  cover property (clearAllSummary ##1 state_q.summary == 8'h00);
  c_mask_write: cover property (regWrEn && regAddr == 8'h01 && regWrData == 8'h00);
  c_held_flag:  cover property ((regRdEn && regAddr == 8'h03 && rawSummary[0]) ##1 state_q.summary[0]);

endmodule : pia_irq_summary

// File: testbench/pia_host_model.sv
// Host side of the command-code register port: single-byte reads and writes.
// Assumes requests launch just after a rising mclk edge and hold until taken.
module pia_host_model (
  input  wire logic       mclk,
  input  wire logic [7:0] regRdData,
  output logic      [7:0] regAddr,
  output logic            regWrEn,
  output logic      [7:0] regWrData,
  output logic            regRdEn
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus at time zero
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end

  // One write, taken at the next edge; released lines show inverted values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge mclk);
    #1;
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask : wr

  // One read; the byte is there once the taking edge has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge mclk);
    #1;
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData;
  endtask : rd
endmodule : pia_host_model

// File: testbench/pse_interrupt_aggregator_bench.sv
// Self-checking bench for the interrupt summary, enable and pin logic.
// Assumes the host model drives the register port; flags come from here.
`define CHK(nm, ex, gt) begin nTests++; if ((gt) !== (ex)) begin failCount++; $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module pse_interrupt_aggregator_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        autoMode = 1'b1;
  logic        clearAllSummary = 1'b0;
  logic        globalIrqEnable = 1'b0;
  logic [34:0] fl = '0;
  logic [7:0]  regAddr, regWrData, regRdData, rdv, sumExp, enExp, code;
  logic        regWrEn, regRdEn, irqN;
  int          failCount = 0;
  int          nTests = 0;
  int          cyc = 0;
  logic [7:0]  corCodes [5] = '{pia_pkg::CMD_POWER_COR, pia_pkg::CMD_DETECT_COR, pia_pkg::CMD_FAULT_COR,
                                pia_pkg::CMD_START_COR, pia_pkg::CMD_SUPPLY_COR};

  pia_irq_summary DUT (.mclk(mclk), .srst(srst), .thermalShutdownFlag(fl[0]), .logicSupplyUvFlag(fl[1]),
    .powerSupplyUvFlag(fl[2]), .portStartFaultFlag(fl[6:3]), .portOvercurrentCutFlag(fl[10:7]),
    .portCurrentLimitFlag(fl[14:11]), .portClassificationFlag(fl[18:15]), .portDetectionFlag(fl[22:19]),
    .portDisconnectFlag(fl[26:23]), .portPowerGoodChangeFlag(fl[30:27]), .portPowerEnableChangeFlag(fl[34:31]),
    .globalIrqEnable(globalIrqEnable), .autoMode(autoMode), .clearAllSummary(clearAllSummary),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .irqN(irqN));
  pia_host_model host (.mclk(mclk), .regRdData(regRdData), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn));

  // Clock and hang guard
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      failCount++;
      giveVerdict();
    end
  end

  // Expected summary byte from a flag vector
  function automatic logic [7:0] sumOf(input logic [34:0] f);
    return {|f[2:0], |f[6:3], |f[14:7], |f[18:15], |f[22:19], |f[26:23], |f[30:27], |f[34:31]};
  endfunction : sumOf

  // Summary bits dropped by a clear-on-read code
  function automatic logic [7:0] corMask(input logic [7:0] c);
    case (c)
      8'h03: return pia_pkg::CLR_POWER;
      8'h05: return pia_pkg::CLR_DETECT;
      8'h07: return pia_pkg::CLR_FAULT;
      8'h09: return pia_pkg::CLR_START;
      8'h0b: return pia_pkg::CLR_SUPPLY;
      default: return 8'h00;
    endcase
  endfunction : corMask

  task automatic doReset(input logic am);
    srst = 1'b1;
    autoMode = am;
    repeat (3) @(posedge mclk);
    #1;
    srst = 1'b0;
    sumExp = pia_pkg::SUMMARY_RESET;
    enExp = pia_pkg::ENABLE_RESET | (am ? pia_pkg::ENABLE_AUTO_MASK : 8'h00);
  endtask : doReset

  // One-cycle flag pulse
  task automatic pulse(input logic [34:0] f);
    @(posedge mclk);
    #1;
    fl = f;
    @(posedge mclk);
    #1;
    fl = '0;
    sumExp |= sumOf(f);
  endtask : pulse

  task automatic clearAll;
    @(posedge mclk);
    #1;
    clearAllSummary = 1'b1;
    @(posedge mclk);
    #1;
    clearAllSummary = 1'b0;
    sumExp = 8'h00;
  endtask : clearAll

  // Pin, summary and enable against the expected state
  task automatic chkState;
    repeat (2) @(posedge mclk);
    #1;
    `CHK("irqN", !(globalIrqEnable && |(sumExp & enExp)), irqN)
    host.rd(pia_pkg::CMD_SUMMARY, rdv);
    `CHK("summary", sumExp, rdv)
    host.rd(pia_pkg::CMD_ENABLE, rdv);
    `CHK("enable", enExp, rdv)
  endtask : chkState

  task automatic giveVerdict;
    $display("comparisons %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : giveVerdict

  initial begin
    void'($urandom(32'h35f6));
    doReset(1'b1);
    chkState();
    doReset(1'b0);
    chkState();
    $display("test reset values done");
    // Each flag alone reaches its own summary bit
    globalIrqEnable = 1'b1;
    enExp = 8'hff;
    host.wr(pia_pkg::CMD_ENABLE, enExp);
    for (int k = 0; k < 35; k++) begin
      clearAll();
      pulse(35'(1) << k);
      chkState();
    end
    $display("test flag mapping done");
    // Plain and clearing event codes
    for (int c = 2; c < 12; c++) begin
      pulse('1);
      host.rd(8'(c), rdv);
      `CHK("unowned", 8'h00, rdv)
      sumExp &= ~corMask(8'(c));
      chkState();
    end
    // A flag held through its clearing read keeps the bit
    @(posedge mclk);
    #1;
    fl[31] = 1'b1;
    host.rd(pia_pkg::CMD_POWER_COR, rdv);
    sumExp = (sumExp & ~pia_pkg::CLR_POWER) | 8'h01;
    chkState();
    fl[31] = 1'b0;
    $display("test clear codes done");
    // Random masks, global enable, flags and clears
    for (int i = 0; i < 80; i++) begin
      globalIrqEnable = 1'($urandom);
      enExp = 8'($urandom);
      host.wr(pia_pkg::CMD_ENABLE, enExp);
      host.wr(pia_pkg::CMD_SUMMARY, 8'($urandom));
      pulse(35'({$urandom, $urandom} & {$urandom, $urandom} & {$urandom, $urandom}));
      chkState();
      if ($urandom % 4 == 0) begin
        clearAll();
      end else begin
        code = corCodes[$urandom % 5];
        host.rd(code, rdv);
        sumExp &= ~corMask(code);
      end
      chkState();
    end
    $display("test random traffic done");
    giveVerdict();
  end
endmodule : pse_interrupt_aggregator_bench
